// ---- clock_gate_regs.vh ----
// Register offsets, field positions and reset values of the clock gate and reset slice
`ifndef CLOCK_GATE_REGS_VH
`define CLOCK_GATE_REGS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_RESET_CONTROL_ZERO  12'h040
`define OFS_CAPABILITY_ONE      12'h010
`define OFS_RUN_CLOCK_CONFIG    12'h060
`define OFS_RUN_PORT_GATE       12'h108
`define OFS_SLEEP_PORT_GATE     12'h118
`define OFS_DEEP_PORT_GATE      12'h128
`define OFS_POWER_STATE         12'h200
`define OFS_IRQ_STATUS          12'h204
`define OFS_IRQ_MASK            12'h208

// ----------------------------------------------------------------
// Field layout
// ----------------------------------------------------------------
`define PORT_GATE_WIDTH         5
`define PORT_GATE_MASK          32'h0000_001F
`define RESET_WATCHDOG_BIT      3
`define RESET_ADC_BIT           16
`define RESET_ZERO_MASK         32'h0001_0008
`define AUTO_GATE_BIT           27
`define CAPABILITY_RESET        32'h0001_0008

// ----------------------------------------------------------------
// Power states and reset values
// ----------------------------------------------------------------
`define PWR_RUN                 2'h0
`define PWR_SLEEP               2'h1
`define PWR_DEEP                2'h2
`define REG_RESET               32'h0000_0000

// ----------------------------------------------------------------
// Interrupt status bits
// ----------------------------------------------------------------
`define IRQ_FAULT_BIT           0
`define IRQ_BAD_ADDR_BIT        1
`define IRQ_WIDTH               2
`endif

// ---- fault_check.v ----
// Flags peripheral accesses to ports whose clock is stopped
`timescale 1ns/100ps

module fault_check (
  input  wire       periph_req,
  input  wire [2:0] periph_sel,
  input  wire [4:0] active_gate,
  output reg        periph_fault,
  output reg        periph_ok
);

  // Gated port or unknown index gives a fault
  always @* begin
    periph_fault = 1'b0;
    periph_ok    = 1'b0;
    if (periph_req) begin
      if (periph_sel < 3'h5 && active_gate[periph_sel]) begin
        periph_ok = 1'b1;
      end else begin
        periph_fault = 1'b1;
      end
    end
  end

endmodule // fault_check

// ---- gate_reset_asserts.sv ----
// Port-level checks of the clock gate and reset slice
`timescale 1ns/100ps
module gate_reset_asserts (
  input logic        clk,
  input logic        nrst,
  input logic        wb_we_i,
  input logic [11:0] wb_adr_i,
  input logic [31:0] wb_dat_i,
  input logic [31:0] wb_dat_o,
  input logic        wb_ack_o,
  input logic        periph_req,
  input logic [2:0]  periph_sel,
  input logic        periph_ack,
  input logic        periph_err,
  input logic [4:0]  port_clk_en,
  input logic        watchdog_rst,
  input logic        adc0_rst
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  // ----------------------------------------------------------------
  // Peripheral access answers
  // ----------------------------------------------------------------
  property p_gate_ans;
    periph_req && periph_sel < 3'h5 |=>
      periph_ack == port_clk_en[$past(periph_sel)] && periph_err == !periph_ack;
  endproperty
  a_gate_ans: assert property (p_gate_ans) else $error("port answer wrong");
  property p_bad_sel;
    periph_req && periph_sel > 3'h4 |=> periph_err && !periph_ack;
  endproperty
  a_bad_sel: assert property (p_bad_sel) else $error("no fault on bad port");

  // ----------------------------------------------------------------
  // Reset state and causes of output changes
  // ----------------------------------------------------------------
  property p_rst_zero;
    $rose(nrst) |-> port_clk_en == 5'h00 && !watchdog_rst && !adc0_rst;
  endproperty
  a_rst_zero: assert property (p_rst_zero) else $error("outputs not zero");
  property p_wdog_set;
    $rose(watchdog_rst) |-> $past(wb_ack_o && wb_we_i && wb_adr_i == 12'h040 && wb_dat_i[3]);
  endproperty
  a_wdog_set: assert property (p_wdog_set) else $error("watchdog reset uncaused");
  property p_wdog_clr;
    $fell(watchdog_rst) |-> $past(wb_ack_o && wb_we_i && wb_adr_i == 12'h040 && !wb_dat_i[3]);
  endproperty
  a_wdog_clr: assert property (p_wdog_clr) else $error("watchdog release uncaused");
  property p_adc_set;
    $rose(adc0_rst) |-> $past(wb_ack_o && wb_we_i && wb_adr_i == 12'h040 && wb_dat_i[16]);
  endproperty
  a_adc_set: assert property (p_adc_set) else $error("converter reset uncaused");
  property p_gate_cause;
    !$stable(port_clk_en) |-> $past(wb_ack_o && wb_we_i);
  endproperty
  a_gate_cause: assert property (p_gate_cause) else $error("gate moved unwritten");

  // ----------------------------------------------------------------
  // Read-only fields
  // ----------------------------------------------------------------
  property p_rd_upper;
    wb_ack_o && !wb_we_i && wb_adr_i == 12'h128 |-> wb_dat_o < 32'h0000_0020;
  endproperty
  a_rd_upper: assert property (p_rd_upper) else $error("gate upper bits set");
  property p_rd_rst;
    wb_ack_o && !wb_we_i && wb_adr_i == 12'h040 |-> (wb_dat_o & ~32'h0001_0008) == 32'h0000_0000;
  endproperty
  a_rd_rst: assert property (p_rd_rst) else $error("reset reserved bits set");
endmodule // gate_reset_asserts

bind peripheral_clock_gate_reset gate_reset_asserts u_gate_reset_asserts (.clk(clk),
  .nrst(nrst), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .periph_req(periph_req),
  .periph_sel(periph_sel), .periph_ack(periph_ack), .periph_err(periph_err),
  .port_clk_en(port_clk_en), .watchdog_rst(watchdog_rst), .adc0_rst(adc0_rst));

// ---- gate_select.v ----
// Chooses the active port clock enables from the power state
`timescale 1ns/100ps
`include "clock_gate_regs.vh"

module gate_select (
  input  wire [1:0] power_state,
  input  wire       auto_gate,
  input  wire [4:0] run_gate,
  input  wire [4:0] sleep_gate,
  input  wire [4:0] deep_gate,
  output reg  [4:0] active_gate
);

  // Sleep sets apply only with auto gating on
  always @* begin
    active_gate = run_gate;
    if (auto_gate) begin
      case (power_state)
        `PWR_SLEEP: active_gate = sleep_gate;
        `PWR_DEEP:  active_gate = deep_gate;
        default:    active_gate = run_gate;
      endcase
    end
  end

endmodule // gate_select

// ---- peripheral_clock_gate_reset.v ----
// Port clock gating, software reset control and Wishbone register slave
//
// Functional notes
// - Each deep-sleep gate bit is a clock enable for one port.
// - Access to a port with its clock stopped answers with a bus fault.
// - All gating bits are zero after reset; ports start unclocked.
// - Run, sleep or deep-sleep gate set chosen by power state.
// - Sleep and deep-sleep sets apply only with auto gating set.
// - Deep-sleep bits 0 to 4 gate ports A to E, read-write.
// - Deep-sleep bits 31:5 read as zero and ignore writes.
// - Writes to reset control zero are masked by capability mask one.
// - Bit 16 of reset control zero resets converter module 0.
// - Bit 3 of reset control zero resets the watchdog.
// - Reset control zero resets to zero; other bits read zero.
`timescale 1ns/100ps
`include "clock_gate_regs.vh"

module peripheral_clock_gate_reset (
  input  wire        clk,
  input  wire        nrst,
  // Wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [11:0] wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  output reg         wb_err_o,
  // Peripheral access check
  input  wire        periph_req,
  input  wire [2:0]  periph_sel,
  output reg         periph_ack,
  output reg         periph_err,
  // Port clock enables and unit resets
  output reg  [4:0]  port_clk_en,
  output reg         watchdog_rst,
  output reg         adc0_rst,
  output reg         irq
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg  [31:0] reset_control_zero_q;
  reg  [31:0] capability_mask_one_q;
  reg         auto_clock_gate_select_q;
  reg  [4:0]  run_port_clock_gate_q;
  reg  [4:0]  sleep_port_clock_gate_q;
  reg  [4:0]  deep_sleep_port_clock_gate_q;
  reg  [1:0]  power_state_q;
  reg  [1:0]  irq_status_q;
  reg  [1:0]  irq_mask_q;
  reg  [31:0] rd_data;
  reg         addr_hit;
  wire [4:0]  active_gate;
  wire        fault_now;
  wire        ok_now;
  wire        bus_req;
  wire        bus_wr;
  wire        bus_rd;
  wire [31:0] lane_mask;
  reg  [1:0]  irq_set;
  // Per-register write strobes
  wire        wr_reset_zero;
  wire        wr_capability;
  wire        wr_run_config;
  wire        wr_run_gate;
  wire        wr_sleep_gate;
  wire        wr_deep_gate;
  wire        wr_power;
  wire        wr_irq_mask;
  wire        rd_irq_status;

  // Byte enables to a bit mask
  function [31:0] sel_mask;
    input [3:0] sel;
    begin
      sel_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    end
  endfunction

  // Merge write data into old value under byte lanes
  function [31:0] merge;
    input [31:0] old_val;
    input [31:0] new_val;
    input [31:0] mask;
    begin
      merge = (old_val & ~mask) | (new_val & mask);
    end
  endfunction

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // One request per cycle, ack gap enforced by ack and error
  assign bus_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
  assign bus_wr    = bus_req & wb_we_i & addr_hit;
  assign bus_rd    = bus_req & ~wb_we_i & addr_hit;
  assign lane_mask = sel_mask(wb_sel_i);

  // Read mux and address hit
  always @* begin
    rd_data  = `REG_RESET;
    addr_hit = 1'b1;
    case (wb_adr_i)
      `OFS_RESET_CONTROL_ZERO: rd_data = reset_control_zero_q & `RESET_ZERO_MASK;
      `OFS_CAPABILITY_ONE:     rd_data = capability_mask_one_q;
      `OFS_RUN_CLOCK_CONFIG:   rd_data[`AUTO_GATE_BIT] = auto_clock_gate_select_q;
      `OFS_RUN_PORT_GATE:      rd_data[4:0] = run_port_clock_gate_q;
      `OFS_SLEEP_PORT_GATE:    rd_data[4:0] = sleep_port_clock_gate_q;
      `OFS_DEEP_PORT_GATE:     rd_data[4:0] = deep_sleep_port_clock_gate_q;
      `OFS_POWER_STATE:        rd_data[1:0] = power_state_q;
      `OFS_IRQ_STATUS:         rd_data[1:0] = irq_status_q;
      `OFS_IRQ_MASK:           rd_data[1:0] = irq_mask_q;
      default:                 addr_hit = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Gate selection and peripheral fault check
  // ----------------------------------------------------------------
  gate_select u_gate_select (
    .power_state (power_state_q),
    .auto_gate   (auto_clock_gate_select_q),
    .run_gate    (run_port_clock_gate_q),
    .sleep_gate  (sleep_port_clock_gate_q),
    .deep_gate   (deep_sleep_port_clock_gate_q),
    .active_gate (active_gate)
  );

  fault_check u_fault_check (
    .periph_req   (periph_req),
    .periph_sel   (periph_sel),
    .active_gate  (active_gate),
    .periph_fault (fault_now),
    .periph_ok    (ok_now)
  );

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  // Write strobes, narrow fields need the lane that holds them
  assign wr_reset_zero = bus_wr & (wb_adr_i == `OFS_RESET_CONTROL_ZERO);
  assign wr_capability = bus_wr & (wb_adr_i == `OFS_CAPABILITY_ONE);
  assign wr_run_config = bus_wr & (wb_adr_i == `OFS_RUN_CLOCK_CONFIG) & wb_sel_i[3];
  assign wr_run_gate   = bus_wr & (wb_adr_i == `OFS_RUN_PORT_GATE) & wb_sel_i[0];
  assign wr_sleep_gate = bus_wr & (wb_adr_i == `OFS_SLEEP_PORT_GATE) & wb_sel_i[0];
  assign wr_deep_gate  = bus_wr & (wb_adr_i == `OFS_DEEP_PORT_GATE) & wb_sel_i[0];
  assign wr_power      = bus_wr & (wb_adr_i == `OFS_POWER_STATE) & wb_sel_i[0];
  assign wr_irq_mask   = bus_wr & (wb_adr_i == `OFS_IRQ_MASK) & wb_sel_i[0];
  assign rd_irq_status = bus_rd & (wb_adr_i == `OFS_IRQ_STATUS);

  // Reset control zero, capability mask limits settable bits
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reset_control_zero_q <= `REG_RESET;
    end else if (wr_reset_zero) begin
      reset_control_zero_q <= merge(reset_control_zero_q, wb_dat_i, lane_mask) &
                              capability_mask_one_q & `RESET_ZERO_MASK;
    end
  end

  // Capability mask one, byte-lane writable
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      capability_mask_one_q <= `CAPABILITY_RESET;
    end else if (wr_capability) begin
      capability_mask_one_q <= merge(capability_mask_one_q, wb_dat_i, lane_mask);
    end
  end

  // Auto clock gate select bit of run clock config
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      auto_clock_gate_select_q <= 1'b0;
    end else if (wr_run_config) begin
      auto_clock_gate_select_q <= wb_dat_i[`AUTO_GATE_BIT];
    end
  end

  // Port gate sets, all ports unclocked from reset
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      run_port_clock_gate_q        <= 5'h0;
      sleep_port_clock_gate_q      <= 5'h0;
      deep_sleep_port_clock_gate_q <= 5'h0;
    end else begin
      if (wr_run_gate) begin
        run_port_clock_gate_q <= wb_dat_i[4:0];
      end
      if (wr_sleep_gate) begin
        sleep_port_clock_gate_q <= wb_dat_i[4:0];
      end
      if (wr_deep_gate) begin
        deep_sleep_port_clock_gate_q <= wb_dat_i[4:0];
      end
    end
  end

  // Power state select
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      power_state_q <= `PWR_RUN;
    end else if (wr_power) begin
      power_state_q <= wb_dat_i[1:0];
    end
  end

  // Interrupt mask
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_mask_q <= 2'h0;
    end else if (wr_irq_mask) begin
      irq_mask_q <= wb_dat_i[1:0];
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status
  // ----------------------------------------------------------------
  // Events: peripheral fault, unmapped bus address
  always @* begin
    irq_set = 2'h0;
    irq_set[`IRQ_FAULT_BIT]    = fault_now;
    irq_set[`IRQ_BAD_ADDR_BIT] = bus_req & ~addr_hit;
  end

  // Read clears, a new event in the same cycle wins
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_status_q <= 2'h0;
    end else if (rd_irq_status) begin
      irq_status_q <= irq_set;
    end else begin
      irq_status_q <= irq_status_q | irq_set;
    end
  end

  // ----------------------------------------------------------------
  // Bus answers and unit outputs
  // ----------------------------------------------------------------
  // One-cycle ack or error, unmapped address gives error
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req & addr_hit;
      wb_err_o <= bus_req & ~addr_hit;
    end
  end

  // Read data stands with ack only, zero otherwise
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wb_dat_o <= `REG_RESET;
    end else begin
      wb_dat_o <= bus_rd ? rd_data : `REG_RESET;
    end
  end

  // Peripheral answer: fault when its clock is off
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      periph_ack <= 1'b0;
      periph_err <= 1'b0;
    end else begin
      periph_ack <= ok_now;
      periph_err <= fault_now;
    end
  end

  // Port clock enables follow the active gate set
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      port_clk_en <= 5'h0;
    end else begin
      port_clk_en <= active_gate;
    end
  end

  // Unit resets held while their bit is set
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      watchdog_rst <= 1'b0;
      adc0_rst     <= 1'b0;
    end else begin
      watchdog_rst <= reset_control_zero_q[`RESET_WATCHDOG_BIT];
      adc0_rst     <= reset_control_zero_q[`RESET_ADC_BIT];
    end
  end

  // Level interrupt from unmasked status bits
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status_q & irq_mask_q);
    end
  end

endmodule // peripheral_clock_gate_reset

// ---- peripheral_clock_gate_reset_tb.sv ----
// Self-checking bench of the clock gate and reset slice
`timescale 1ns/100ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin errors++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module peripheral_clock_gate_reset_tb;
  logic        clk, nrst, cyc, stb, we, req, err;
  logic [11:0] adr;
  logic [3:0]  sel;
  logic [2:0]  psel;
  logic [31:0] dat, q;
  wire  [31:0] rdat;
  wire         ack, werr, pack, perr, wdr, adc_r, irq;
  wire  [4:0]  pce;
  int          errors, cmp_count;

  peripheral_clock_gate_reset u_peripheral_clock_gate_reset (
    .clk(clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(werr),
    .periph_req(req), .periph_sel(psel), .periph_ack(pack), .periph_err(perr),
    .port_clk_en(pce), .watchdog_rst(wdr), .adc0_rst(adc_r), .irq(irq));

  // ----------------------------------------------------------------
  // Bus and port access tasks
  // ----------------------------------------------------------------
  // One classic cycle, held until ack or err is sampled at a rising edge
  task automatic xfer(input [11:0] a, input w, input [31:0] d);
    @(posedge clk);
    {cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, d, 4'hF};
    do begin @(posedge clk); end while (!(ack || werr));
    q = rdat;
    err = werr;
    {cyc, stb, we} <= 3'h0;
  endtask
  task automatic wr(input [11:0] a, input [31:0] d);
    xfer(a, 1'b1, d);
    @(negedge clk);
  endtask
  task automatic rd(input string nm, input [11:0] a, input [31:0] e);
    xfer(a, 1'b0, 32'h0000_0000);
    `CHK(nm, e, q)
  endtask
  // One-cycle access attempt to a port
  task automatic pchk(input [2:0] s, input logic e);
    @(posedge clk);
    {req, psel} <= {1'b1, s};
    @(posedge clk);
    req <= 1'b0;
    @(negedge clk);
    `CHK("periph_ack", e, pack)
    `CHK("periph_err", !e, perr)
  endtask
  task automatic final_report;
    if (errors == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Clock, watchdog and test sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    #200000;
    errors++;
    final_report;
  end
  initial begin
    {nrst, cyc, stb, we, req, adr, sel, dat, psel} = '0;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    `CHK("port_clk_en", 5'h00, pce)
    rd("deep_gate", 12'h128, 32'h0000_0000);
    rd("reset_zero", 12'h040, 32'h0000_0000);
    wr(12'h128, 32'hFFFF_FFFF);
    rd("deep_gate", 12'h128, 32'h0000_001F);
    wr(12'h128, 32'h0000_0015);
    rd("deep_gate", 12'h128, 32'h0000_0015);
    wr(12'h200, 32'h0000_0002);
    `CHK("port_clk_en", 5'h00, pce)
    wr(12'h060, 32'h0800_0000);
    `CHK("port_clk_en", 5'h15, pce)
    for (int i = 0; i < 6; i++) pchk(i[2:0], i < 5 && i != 1 && i != 3);
    wr(12'h118, 32'h0000_000A);
    wr(12'h200, 32'h0000_0001);
    `CHK("port_clk_en", 5'h0A, pce)
    wr(12'h108, 32'h0000_0003);
    wr(12'h200, 32'h0000_0000);
    `CHK("port_clk_en", 5'h03, pce)
    wr(12'h200, 32'h0000_0003);
    `CHK("port_clk_en", 5'h03, pce)
    wr(12'h200, 32'h0000_0002);
    wr(12'h060, 32'h0000_0000);
    `CHK("port_clk_en", 5'h03, pce)
    wr(12'h040, 32'hFFFF_FFFF);
    rd("reset_zero", 12'h040, 32'h0001_0008);
    `CHK("watchdog_rst", 1'b1, wdr)
    `CHK("adc0_rst", 1'b1, adc_r)
    wr(12'h040, 32'h0000_0000);
    `CHK("watchdog_rst", 1'b0, wdr)
    wr(12'h010, 32'h0000_0008);
    rd("capability", 12'h010, 32'h0000_0008);
    wr(12'h040, 32'hFFFF_FFFF);
    rd("reset_zero", 12'h040, 32'h0000_0008);
    `CHK("adc0_rst", 1'b0, adc_r)
    // Fault status raised by the port scan, then masked bad address
    wr(12'h208, 32'h0000_0001);
    `CHK("irq", 1'b1, irq)
    rd("irq_status", 12'h204, 32'h0000_0001);
    repeat (2) @(negedge clk);
    `CHK("irq", 1'b0, irq)
    xfer(12'h300, 1'b0, 32'h0000_0000);
    `CHK("wb_err_o", 1'b1, err)
    repeat (2) @(negedge clk);
    `CHK("irq", 1'b0, irq)
    wr(12'h208, 32'h0000_0003);
    `CHK("irq", 1'b1, irq)
    rd("irq_status", 12'h204, 32'h0000_0002);
    final_report;
  end
endmodule // peripheral_clock_gate_reset_tb
